//--- mpw_mem_model.sv
`timescale 1ns/100ps
module mpw_mem_model (
  input wire logic aclk,
  input wire logic slow,
  input wire mpw_pkg::mpw_mem_req_type mem_req,
  input wire logic mem_valid,
  output logic mem_ready,
  output logic mem_rvalid,
  output logic [63:0] mem_rdata
);
  import mpw_pkg::*;
  logic [63:0] mem [0:63];
  logic [5:0] ra;
  logic [1:0] dly;
  logic pend;
  logic tgl;
  initial begin
    for (int i = 0; i < 64; i++) mem[i] = 64'h0f0f0f0f_0f0f0f0f;
    {pend, tgl, mem_rvalid, dly} = '0;
    mem_rdata = '0;
  end
  // slow mode stalls every other cycle
  assign mem_ready = !slow || tgl;
  always @(posedge aclk) begin
    tgl <= !tgl;
    mem_rvalid <= 1'h0;
    // idle data keeps changing, never a stale copy
    mem_rdata <= ~mem_rdata;
    if (mem_valid && mem_ready) begin
      if (mem_req.write) begin
        for (int b = 0; b < 8; b++)
          if (mem_req.be[b]) mem[mem_req.addr[5:0]][8*b+:8] <= mem_req.wdata[8*b+:8];
      end else begin
        pend <= 1'h1;
        ra <= mem_req.addr[5:0];
        dly <= slow ? 2'h3 : 2'h0;
      end
    end
    if (pend) begin
      if (dly == 2'h0) begin
        mem_rvalid <= 1'h1;
        mem_rdata <= mem[ra];
        pend <= 1'h0;
      end else dly <= dly - 2'h1;
    end
  end
endmodule

//--- mpw_pixel_write.sv
// The register addresses and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/100ps
module mpw_pixel_write (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [mpw_pkg::AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [mpw_pkg::AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output mpw_pkg::mpw_mem_req_type mem_req,
  output logic mem_valid,
  input wire logic mem_ready,
  input wire logic mem_rvalid,
  input wire logic [63:0] mem_rdata
);
  import mpw_pkg::*;

  mpw_state_type st_reg;
  logic aw_got_reg, w_got_reg, ar_got_reg;
  logic [AXI_AW-1:0] awaddr_reg, araddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic [31:0] mode_config_reg, logic_combine_code_reg, plane_mask_reg, pixel_byte_mask_reg;
  logic [15:0] fb_writes_reg;
  logic op_read_reg, q_reg;
  logic [127:0] rbuf_reg;
  logic [1:0] bresp_reg, rresp_reg;
  logic [31:0] rdata_reg;
  mpw_mem_req_type mem_req_reg;

  logic [2:0] src_fmt;
  logic [1:0] src_sel, dst_fmt, dst_sel;
  logic [3:0] logic_combine_code;
  logic unp_src, unp_dst, op_unp;
  logic [3:0] register_byte_mask, wr_mask;
  logic [127:0] src_x, rbuf_next;
  logic [15:0] en_x;
  logic [23:0] op_addr;
  logic q_last;
  logic [63:0] merged;
  logic [7:0] merged_be;
  logic [31:0] fb_view, reg_view;
  logic reg_hit;

  function automatic logic [7:0] lane_get(input logic [31:0] dw, input logic [1:0] sel);
    lane_get = dw[8*sel +: 8];
  endfunction
  function automatic logic [31:0] lane_put(input logic [7:0] px, input logic [1:0] sel);
    lane_put = 32'h0000_0000;
    lane_put[8*sel +: 8] = px;
  endfunction
  function automatic logic [7:0] combine8(input logic [3:0] code, input logic [7:0] s,
                                          input logic [7:0] d);
    for (int i = 0; i < 8; i++) begin
      combine8[i] = code[{~s[i], ~d[i]}];
    end
  endfunction
  function automatic logic [31:0] strobe_merge(input logic [31:0] old, input logic [31:0] nw,
                                               input logic [3:0] strb);
    for (int i = 0; i < 4; i++) begin
      strobe_merge[8*i +: 8] = strb[i] ? nw[8*i +: 8] : old[8*i +: 8];
    end
  endfunction

  assign src_fmt = mode_config_reg[SRC_FMT_LSB +: 3];
  assign src_sel = mode_config_reg[SRC_SEL_LSB +: 2];
  assign dst_fmt = logic_combine_code_reg[DST_FMT_LSB +: 2];
  assign dst_sel = logic_combine_code_reg[DST_SEL_LSB +: 2];
  assign logic_combine_code = logic_combine_code_reg[ROP_LSB +: 4];
  assign unp_src = (src_fmt == SRC_UNPACKED);
  assign unp_dst = (dst_fmt == DST_UNPACKED);
  assign register_byte_mask = pixel_byte_mask_reg[3:0];
  assign wr_mask = wstrb_reg & register_byte_mask;
  assign op_addr = op_read_reg ? araddr_reg[23:0] : awaddr_reg[23:0];
  // writes look at destination fields only
  assign op_unp = op_read_reg ? unp_src : unp_dst;
  // unpacked spans the aligned 16 bytes, two qwords
  assign q_last = op_unp ? 1'b1 : op_addr[3];
  assign reg_hit = (araddr_reg[7:0] <= OFF_STATUS) && (araddr_reg[1:0] == 2'h0);

  // expand the write into a 16-byte window
  always_comb begin
    src_x = 128'h0;
    en_x = 16'h0;
    for (int k = 0; k < 4; k++) begin
      if (unp_dst) begin
        src_x[32*k +: 32] = lane_put(wdata_reg[8*k +: 8], dst_sel);
        en_x[4*k + 32'(dst_sel)] = wr_mask[k];
      end else if (op_addr[3:2] == 2'(k)) begin
        // four maskable bytes at the dword
        src_x[32*k +: 32] = wdata_reg;
        en_x[4*k +: 4] = wr_mask;
      end
    end
  end

  // read-modify-write of one qword
  always_comb begin
    for (int b = 0; b < 8; b++) begin
      logic [7:0] s, d, pm, r;
      s = src_x[64*q_reg + 8*b +: 8];
      d = mem_rdata[8*b +: 8];
      pm = plane_mask_reg[8*(b % 4) +: 8];
      r = combine8(logic_combine_code, s, d);
      merged[8*b +: 8] = (r & pm) | (d & ~pm);
      merged_be[b] = en_x[8*q_reg + b];
    end
  end

  // read view includes the returning qword, so rdata stands with rvalid
  always_comb begin
    rbuf_next = rbuf_reg;
    rbuf_next[64*q_reg +: 64] = mem_rdata;
    fb_view = rbuf_next[32*araddr_reg[3:2] +: 32];
    // source select only on unpacked source reads
    if (unp_src) begin
      for (int k = 0; k < 4; k++) begin
        fb_view[8*k +: 8] = lane_get(rbuf_next[32*k +: 32], src_sel);
      end
    end
  end

  always_comb begin
    case (araddr_reg[7:0])
      OFF_MODE: reg_view = mode_config_reg;
      OFF_ROP: reg_view = logic_combine_code_reg;
      OFF_PMASK: reg_view = plane_mask_reg;
      OFF_PXMASK: reg_view = pixel_byte_mask_reg;
      OFF_STATUS: reg_view = {16'h0, fb_writes_reg};
      default: reg_view = 32'h0;
    endcase
  end

  assign s_axi_awready = !aw_got_reg;
  assign s_axi_wready = !w_got_reg;
  assign s_axi_arready = !ar_got_reg;
  assign s_axi_bvalid = (st_reg == S_BRESP);
  assign s_axi_rvalid = (st_reg == S_RRESP);
  assign s_axi_bresp = bresp_reg;
  assign s_axi_rresp = rresp_reg;
  assign s_axi_rdata = rdata_reg;
  assign mem_req = mem_req_reg;
  assign mem_valid = (st_reg == S_RREQ) || (st_reg == S_WREQ);

  // address and data captured in either order, held to the response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      ar_got_reg <= 1'b0;
      awaddr_reg <= '0;
      araddr_reg <= '0;
      wdata_reg <= 32'h0;
      wstrb_reg <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        ar_got_reg <= 1'b1;
        araddr_reg <= s_axi_araddr;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        aw_got_reg <= 1'b0;
        w_got_reg <= 1'b0;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        ar_got_reg <= 1'b0;
      end
    end
  end

  // one access at a time; writes win over reads
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= S_IDLE;
      op_read_reg <= 1'b0;
      q_reg <= 1'b0;
      rbuf_reg <= 128'h0;
      mem_req_reg <= '0;
      bresp_reg <= RESP_OKAY;
      rresp_reg <= RESP_OKAY;
      rdata_reg <= 32'h0;
    end else begin
      case (st_reg)
        S_IDLE: begin
          if (aw_got_reg && w_got_reg) begin
            op_read_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
            if (awaddr_reg[FB_SEL_BIT]) begin
              st_reg <= S_RREQ;
              q_reg <= unp_dst ? 1'b0 : awaddr_reg[3];
              mem_req_reg <= '{1'b0, {awaddr_reg[23:4], (unp_dst ? 1'b0 : awaddr_reg[3])},
                               64'h0, 8'h00};
            end else begin
              st_reg <= S_BRESP;
              if ((awaddr_reg[7:0] > OFF_PXMASK) || (awaddr_reg[1:0] != 2'h0)) begin
                bresp_reg <= RESP_SLVERR;
              end
            end
          end else if (ar_got_reg) begin
            op_read_reg <= 1'b1;
            if (araddr_reg[FB_SEL_BIT]) begin
              st_reg <= S_RREQ;
              q_reg <= unp_src ? 1'b0 : araddr_reg[3];
              mem_req_reg <= '{1'b0, {araddr_reg[23:4], (unp_src ? 1'b0 : araddr_reg[3])},
                               64'h0, 8'h00};
            end else begin
              st_reg <= S_RRESP;
              rdata_reg <= reg_view;
              rresp_reg <= reg_hit ? RESP_OKAY : RESP_SLVERR;
            end
          end
        end
        S_RREQ: begin
          if (mem_ready) st_reg <= S_RWAIT;
        end
        S_RWAIT: begin
          if (mem_rvalid) begin
            if (op_read_reg) begin
              rbuf_reg <= rbuf_next;
              if (q_reg == q_last) begin
                st_reg <= S_RRESP;
                rresp_reg <= RESP_OKAY;
                rdata_reg <= fb_view;
              end else begin
                st_reg <= S_RREQ;
                q_reg <= 1'b1;
                mem_req_reg.addr[0] <= 1'b1;
              end
            end else begin
              st_reg <= S_WREQ;
              mem_req_reg <= '{1'b1, mem_req_reg.addr, merged, merged_be};
            end
          end
        end
        S_WREQ: begin
          if (mem_ready) begin
            if (q_reg == q_last) begin
              st_reg <= S_BRESP;
            end else begin
              st_reg <= S_RREQ;
              q_reg <= 1'b1;
              mem_req_reg <= '{1'b0, {mem_req_reg.addr[FB_AW-1:1], 1'b1}, 64'h0, 8'h00};
            end
          end
        end
        S_BRESP: begin
          if (s_axi_bready) st_reg <= S_IDLE;
        end
        S_RRESP: begin
          if (s_axi_rready) st_reg <= S_IDLE;
        end
        default: st_reg <= S_IDLE;
      endcase
    end
  end

  // control registers; no access overlaps a frame-buffer operation
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_config_reg <= MODE_RST;
      logic_combine_code_reg <= ROP_RST;
      plane_mask_reg <= PMASK_RST;
      pixel_byte_mask_reg <= PXMASK_ALL;
      fb_writes_reg <= 16'h0;
    end else if (st_reg == S_IDLE && aw_got_reg && w_got_reg && !awaddr_reg[FB_SEL_BIT]) begin
      case (awaddr_reg[7:0])
        OFF_MODE: mode_config_reg <= strobe_merge(mode_config_reg, wdata_reg, wstrb_reg);
        OFF_ROP: logic_combine_code_reg <= strobe_merge(logic_combine_code_reg, wdata_reg, wstrb_reg);
        OFF_PMASK: plane_mask_reg <= strobe_merge(plane_mask_reg, wdata_reg, wstrb_reg);
        OFF_PXMASK: begin
          pixel_byte_mask_reg <= strobe_merge(pixel_byte_mask_reg, wdata_reg, wstrb_reg);
        end
        default: fb_writes_reg <= fb_writes_reg;
      endcase
    end else if (st_reg == S_WREQ && mem_ready && q_reg == q_last) begin
      // unmask all bytes after each frame-buffer write
      pixel_byte_mask_reg <= PXMASK_ALL;
      fb_writes_reg <= fb_writes_reg + 16'h1;
    end
  end
endmodule

//--- mpw_pixel_write_checker.sv
`timescale 1ns/100ps
module mpw_pixel_write_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [mpw_pkg::AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [mpw_pkg::AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire mpw_pkg::mpw_mem_req_type mem_req,
  input wire logic mem_valid,
  input wire logic mem_ready,
  input wire logic mem_rvalid
);
  import mpw_pkg::*;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence fb_read_taken;
    mem_valid && mem_ready && !mem_req.write;
  endsequence
  sequence reg_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      && !s_axi_awaddr[FB_SEL_BIT] && s_axi_arready && !s_axi_rvalid;
  endsequence
  chk_b_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  chk_r_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("read response dropped");
  chk_mem_hold: assert property (mem_valid && !mem_ready |=> mem_valid && $stable(mem_req))
    else $error("memory request changed while stalled");
  chk_wr_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("new write taken before response");
  chk_rmw_gap: assert property (fb_read_taken |=> !mem_valid)
    else $error("request issued before stored data returned");
  chk_write_order: assert property ($rose(mem_valid) && mem_req.write |-> $past(mem_rvalid))
    else $error("pixel write without stored data");
  chk_reg_bresp: assert property (reg_wr_taken |=> !s_axi_awready ##1 s_axi_bvalid)
    else $error("register write answer late");
  chk_reg_rresp: assert property (s_axi_arvalid && s_axi_arready && !s_axi_araddr[FB_SEL_BIT]
      && s_axi_awready && !s_axi_awvalid |=> ##1 s_axi_rvalid)
    else $error("register read answer late");
  chk_reset_idle: assert property (disable iff (1'h0)
      !aresetn |=> !s_axi_bvalid && !s_axi_rvalid && !mem_valid)
    else $error("outputs busy after reset");
endmodule
bind mpw_pixel_write mpw_pixel_write_checker u_chk (.*);

//--- mpw_pkg.sv
package mpw_pkg;
  localparam int AXI_AW = 32;
  localparam int FB_AW = 21;
  localparam int FB_SEL_BIT = 24;
  localparam logic [7:0] OFF_MODE = 8'h00;
  localparam logic [7:0] OFF_ROP = 8'h04;
  localparam logic [7:0] OFF_PMASK = 8'h08;
  localparam logic [7:0] OFF_PXMASK = 8'h0c;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  localparam int SRC_FMT_LSB = 8;
  localparam int SRC_SEL_LSB = 11;
  localparam int DST_FMT_LSB = 8;
  localparam int DST_SEL_LSB = 10;
  localparam int ROP_LSB = 0;
  localparam logic [2:0] SRC_PACKED = 3'h0;
  localparam logic [2:0] SRC_UNPACKED = 3'h1;
  localparam logic [1:0] DST_PACKED = 2'h0;
  localparam logic [1:0] DST_UNPACKED = 2'h1;
  localparam logic [1:0] LANE_TAG = 2'h3;
  localparam logic [31:0] MODE_RST = 32'h0000_0000;
  localparam logic [31:0] ROP_RST = 32'h0000_0003;
  localparam logic [31:0] PMASK_RST = 32'hffff_ffff;
  localparam logic [31:0] PXMASK_ALL = 32'hffff_ffff;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef struct packed {
    logic write;
    logic [FB_AW-1:0] addr;
    logic [63:0] wdata;
    logic [7:0] be;
  } mpw_mem_req_type;
  typedef enum {S_IDLE, S_RREQ, S_RWAIT, S_WREQ, S_BRESP, S_RRESP} mpw_state_type;
endpackage

//--- tb_masked_pixel_write_path.sv
`timescale 1ns/100ps
module tb_masked_pixel_write_path;
  import mpw_pkg::*;
  typedef struct {logic [31:0] rop, pm, bm, d; logic [3:0] s; logic [31:0] e;} mpw_row_type;
  localparam logic [31:0] FB = 32'h0100_0000;
  logic aclk = 0, aresetn = 0, slow = 0;
  logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0, s_axi_rdata, rd, e;
  logic [3:0] s_axi_wstrb = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, mem_valid, mem_ready, mem_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic [63:0] mem_rdata;
  mpw_mem_req_type mem_req;
  int n_fail = 0, n_tests = 0, cyc = 0;
  mpw_row_type t [6] = '{
    '{32'h3, 32'hffffffff, 32'hffffffff, 32'h12345678, 4'hf, 32'h12345678},
    '{32'h0, 32'hffffffff, 32'hffffffff, 32'h12345678, 4'hf, 32'h00000000},
    '{32'h6, 32'hffffffff, 32'hffffffff, 32'hffff0000, 4'hf, 32'hf0f00f0f},
    '{32'h3, 32'h0000ffff, 32'hffffffff, 32'haaaaaaaa, 4'hf, 32'h0f0faaaa},
    '{32'h3, 32'hffffffff, 32'h00000005, 32'h11223344, 4'he, 32'h0f220f0f},
    '{32'hc03, 32'hffffffff, 32'hffffffff, 32'h87654321, 4'h3, 32'h0f0f4321}};
  logic [31:0] rv [5] = '{MODE_RST, ROP_RST, PMASK_RST, PXMASK_ALL, 32'h0};
  mpw_pixel_write DUT (.*);
  mpw_mem_model mdl (.*);
  initial forever #4 aclk = ~aclk;
  function automatic logic [31:0] rop(logic [3:0] c, logic [31:0] s, d);
    rop = ({32{c[0]}} & s & d) | ({32{c[1]}} & s & ~d) | ({32{c[2]}} & ~s & d)
        | ({32{c[3]}} & ~s & ~d);
  endfunction
  task automatic stop_test();
    $display("tests %0d fails %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [63:0] g, x);
    n_tests++;
    if (g !== x) begin
      n_fail++;
      $display("mismatch at %0t: got %h want %h", $time, g, x);
    end
  endtask
  task automatic wr(input logic [31:0] a, d, input logic [3:0] s);
    logic bt;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    bt = 1'h0;
    while (!bt) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
      bt = s_axi_bvalid;
      rs = s_axi_bresp;
    end
    s_axi_bready <= 1'h0;
  endtask
  task automatic rdr(input logic [31:0] a);
    logic v;
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    v = 1'h0;
    while (!v) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
      v = s_axi_rvalid;
      rd = s_axi_rdata;
      rs = s_axi_rresp;
    end
    s_axi_rready <= 1'h0;
  endtask
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      stop_test();
    end
  end
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'h1;
    for (int i = 0; i < 5; i++) begin
      rdr(32'(i * 4));
      chk(rd, rv[i]);
    end
    // unpacked source setting must not touch pixel writes
    wr(OFF_MODE, 32'h1900, 4'hf);
    foreach (t[i]) begin
      wr(OFF_ROP, t[i].rop, 4'hf);
      wr(OFF_PMASK, t[i].pm, 4'hf);
      wr(OFF_PXMASK, t[i].bm, 4'hf);
      wr(FB | 32'(i * 8), t[i].d, t[i].s);
      chk(rs, RESP_OKAY);
      chk(mdl.mem[i], {32'h0f0f0f0f, t[i].e});
      rdr(OFF_PXMASK);
      chk(rd, 32'hffffffff);
      rdr(OFF_ROP);
      chk(rd, t[i].rop);
    end
    for (int c = 0; c < 16; c++) begin
      slow <= c[0];
      wr(OFF_ROP, 32'(c), 4'hf);
      wr(FB | 32'(64 + c * 8), 32'h3355aacc, 4'hf);
      chk(mdl.mem[8 + c], {32'h0f0f0f0f, rop(4'(c), 32'h3355aacc, 32'h0f0f0f0f)});
    end
    for (int l = 0; l < 4; l++) begin
      wr(OFF_ROP, 32'h103 | 32'(l << 10), 4'hf);
      wr(FB | 32'(256 + l * 16), 32'h44332211, 4'hb);
      for (int k = 0; k < 4; k++) begin
        e = 32'h0f0f0f0f;
        if (k != 2) e[8*l+:8] = 8'(8'h11 * (k + 1));
        chk(mdl.mem[32 + 2 * l + k / 2][32*(k%2)+:32], e);
      end
    end
    for (int l = 0; l < 4; l++) begin
      wr(OFF_MODE, 32'h100 | 32'(l << 11), 4'hf);
      rdr(FB | 32'(256 + l * 16));
      chk(rd, 32'h440f2211);
    end
    wr(OFF_MODE, 32'h1800, 4'hf);
    rdr(FB | 32'h104);
    chk(rd, 32'h0f0f0f22);
    chk(rs, RESP_OKAY);
    wr(OFF_STATUS, 32'h0, 4'hf);
    chk(rs, RESP_SLVERR);
    wr(32'h14, 32'h0, 4'hf);
    chk(rs, RESP_SLVERR);
    rdr(32'h14);
    chk(rs, RESP_SLVERR);
    rdr(OFF_STATUS);
    chk(rd[15:0], 16'h1a);
    aresetn <= 1'h0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'h1;
    rdr(OFF_ROP);
    chk(rd, ROP_RST);
    stop_test();
  end
endmodule
